/* File: shared/pwa_map.svh */
// Register map, field positions, reset values and limits of the power averager
`ifndef PWA_MAP_SVH
`define PWA_MAP_SVH

// ********
// Offsets
// ********
`define PWA_A_CTRL     8'h00
`define PWA_A_COUNT    8'h04
`define PWA_A_CARRIER  8'h08
`define PWA_A_GAIN     8'h0C
`define PWA_A_PULSE    8'h10
`define PWA_A_OFFSET   8'h14
`define PWA_A_CHAN     8'h18
`define PWA_A_STATUS   8'h1C

// ********
// Control fields
// ********
`define PWA_B_AVG_EN   0
`define PWA_B_REPEAT   1
`define PWA_B_PULSE_EN 2
`define PWA_B_OFS_EN   3
`define PWA_B_CLEAR    4

// ********
// Reset values and limits
// ********
`define PWA_R_COUNT    17'h00004
// Carrier in kHz, 10.0e9 Hz
`define PWA_R_CARRIER  32'h00989680
// Gain is Q2.14, so this is unity
`define PWA_R_GAIN     16'h4000
// Pulse fraction in 0.001 percent steps
`define PWA_R_PULSE    17'h003E8
`define PWA_CNT_MAX    17'h10000
`define PWA_PULSE_MAX  17'h186A0
// Offset in 0.01 dB steps
`define PWA_OFS_MAX    16'h4E20
`define PWA_CHAN_MAX   2'h2
`define PWA_GAIN_SHIFT 14
`define PWA_DB_PER_OCT 9'h12D
`define PWA_DIV_STEPS  6'h30

`endif

/* File: shared/pwa_pkg.sv */
// Types shared by the power averager
`default_nettype none
package pwa_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_diva = 3'h1,
    st_gain = 3'h2,
    st_divd = 3'h3,
    st_log  = 3'h4,
    st_emit = 3'h5
  } pwa_state_t;
endpackage
`default_nettype wire

/* File: shared/pwa_fifo_if.sv */
// Result FIFO carrier between averager and its buffer
`timescale 1ns/100ps
`default_nettype none
interface pwa_fifo_if #(parameter int W = 56);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport user  (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
  modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

/* File: logic/pwa_fifo.sv */
// Result FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pwa_fifo #(
  parameter int W = 56,
  parameter int D = 8
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  pwa_fifo_if.store   f
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign f.wr_ready = (cnt_q != (AW+1)'(D));
  assign f.rd_valid = (cnt_q != '0);
  assign f.rd_data  = mem[rp_q];
  assign push       = f.wr_valid && f.wr_ready;
  assign pop        = f.rd_valid && f.rd_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= f.wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pwa_fifo
`default_nettype wire

/* File: logic/pwa_averager.sv */
// Power reading averager with corrections and result FIFO
`timescale 1ns/100ps
`default_nettype none
`include "pwa_map.svh"
module pwa_averager (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        rdg_valid,
  input  wire logic [23:0] rdg_data,
  output logic             rdg_ready,
  output logic             res_valid,
  input  wire logic        res_ready,
  output logic      [31:0] res_power,
  output logic      [23:0] res_level,
  output logic      [1:0]  trace_chan_sel
);
  // ********
  // Reset release
  // ********
  logic rst_s1_q;
  logic srst_n_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      srst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      srst_n_q <= rst_s1_q;
    end
  end

  // ********
  // Declarations
  // ********
  logic              avg_en_q;
  logic              repeat_q;
  logic              pf_en_q;
  logic              ofs_en_q;
  logic              filt_clr_q;
  logic [16:0]       count_q;
  logic [31:0]       carrier_q;
  logic [15:0]       gain_q;
  logic [16:0]       pf_q;
  logic [15:0]       ofs_q;
  logic [1:0]        chan_q;
  logic [31:0]       rdata_q;
  logic              cnt_ok;
  logic              pf_ok;
  logic              ofs_ok;
  pwa_pkg::pwa_state_t st_q;
  logic [23:0]       win_mem [65536];
  logic [23:0]       old_q;
  logic [39:0]       sum_q;
  logic [16:0]       len_q;
  logic [15:0]       wp_q;
  logic [16:0]       fresh_q;
  logic              accept;
  logic              acc_q;
  logic              full;
  logic              emit_now;
  logic [16:0]       len_d;
  logic [39:0]       sum_d;
  logic [31:0]       val_q;
  logic [23:0]       lvl_q;
  logic [23:0]       lvl_d;
  logic [47:0]       gprod;
  logic [31:0]       gval;
  logic [48:0]       dnum;
  logic [4:0]        msb;
  logic [31:0]       norm;
  logic [17:0]       dbx;
  logic              div_go;
  logic [47:0]       div_num;
  logic [16:0]       div_den_d;
  logic              div_run_q;
  logic [5:0]        div_cnt_q;
  logic [47:0]       div_quo_q;
  logic [17:0]       div_rem_q;
  logic [16:0]       div_den_q;
  logic [17:0]       trial;
  logic              div_done;

  pwa_fifo_if #(.W(56)) fif ();

  // ********
  // Register port
  // ********
  assign cnt_ok = (reg_wdata != 32'h0) && (reg_wdata <= {15'h0, `PWA_CNT_MAX});
  assign pf_ok  = (reg_wdata != 32'h0) && (reg_wdata <= {15'h0, `PWA_PULSE_MAX});
  assign ofs_ok = ($signed(reg_wdata[15:0]) <= $signed(`PWA_OFS_MAX))
               && ($signed(reg_wdata[15:0]) >= -$signed(`PWA_OFS_MAX));

  always_ff @(posedge core_clk or negedge srst_n_q) begin
    if (!srst_n_q) begin
      avg_en_q  <= 1'b1;
      repeat_q  <= 1'b1;
      pf_en_q   <= 1'b0;
      ofs_en_q  <= 1'b0;
      count_q   <= `PWA_R_COUNT;
      carrier_q <= `PWA_R_CARRIER;
      gain_q    <= `PWA_R_GAIN;
      pf_q      <= `PWA_R_PULSE;
      ofs_q     <= 16'h0000;
      chan_q    <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `PWA_A_CTRL: begin
          avg_en_q <= reg_wdata[`PWA_B_AVG_EN];
          repeat_q <= reg_wdata[`PWA_B_REPEAT];
          pf_en_q  <= reg_wdata[`PWA_B_PULSE_EN];
          ofs_en_q <= reg_wdata[`PWA_B_OFS_EN];
        end
        `PWA_A_COUNT: begin
          if (cnt_ok) begin
            count_q <= reg_wdata[16:0];
          end
        end
        `PWA_A_CARRIER: carrier_q <= reg_wdata;
        `PWA_A_GAIN:    gain_q <= reg_wdata[15:0];
        `PWA_A_PULSE: begin
          if (pf_ok) begin
            pf_q <= reg_wdata[16:0];
          end
        end
        `PWA_A_OFFSET: begin
          if (ofs_ok) begin
            ofs_q <= reg_wdata[15:0];
          end
        end
        `PWA_A_CHAN: begin
          if (reg_wdata[31:2] == 30'h0 && reg_wdata[1:0] <= `PWA_CHAN_MAX) begin
            chan_q <= reg_wdata[1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Count change also restarts the window so it never holds more than the count
  always_ff @(posedge core_clk or negedge srst_n_q) begin
    if (!srst_n_q) begin
      filt_clr_q <= 1'b0;
    end else begin
      filt_clr_q <= reg_wr && (((reg_addr == `PWA_A_CTRL) && reg_wdata[`PWA_B_CLEAR])
                               || ((reg_addr == `PWA_A_COUNT) && cnt_ok));
    end
  end

  always_ff @(posedge core_clk or negedge srst_n_q) begin
    if (!srst_n_q) begin
      rdata_q <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `PWA_A_CTRL:    rdata_q <= {28'h0, ofs_en_q, pf_en_q, repeat_q, avg_en_q};
        `PWA_A_COUNT:   rdata_q <= {15'h0, count_q};
        `PWA_A_CARRIER: rdata_q <= carrier_q;
        `PWA_A_GAIN:    rdata_q <= {16'h0, gain_q};
        `PWA_A_PULSE:   rdata_q <= {15'h0, pf_q};
        `PWA_A_OFFSET:  rdata_q <= {{16{ofs_q[15]}}, ofs_q};
        `PWA_A_CHAN:    rdata_q <= {30'h0, chan_q};
        `PWA_A_STATUS:  rdata_q <= {13'h0, st_q != pwa_pkg::st_idle, full, len_q};
        default:        rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign reg_rdata      = rdata_q;
  assign trace_chan_sel = chan_q;

  // ********
  // Averaging window, used in both repeat and every_value_output modes
  // ********
  // Reading is refused while busy, in the clear cycle, or right after a take
  assign rdg_ready = (st_q == pwa_pkg::st_idle) && !filt_clr_q && !acc_q;
  assign accept    = rdg_valid && rdg_ready;
  assign full      = (len_q == count_q);
  assign len_d     = full ? len_q : len_q + 17'h00001;
  assign sum_d     = sum_q + {16'h0, rdg_data} - (full ? {16'h0, old_q} : 40'h0);
  assign emit_now  = !avg_en_q || !repeat_q || (fresh_q + 17'h00001 >= count_q);

  // Oldest-entry read is registered, so a reading right behind a take would subtract a stale entry
  always_ff @(posedge core_clk or negedge srst_n_q) begin
    if (!srst_n_q) begin
      acc_q <= 1'b0;
    end else begin
      acc_q <= accept;
    end
  end

  always_ff @(posedge core_clk) begin
    if (accept && avg_en_q) begin
      win_mem[wp_q] <= rdg_data;
    end
    old_q <= win_mem[wp_q - len_q[15:0]];
  end

  always_ff @(posedge core_clk or negedge srst_n_q) begin
    if (!srst_n_q) begin
      sum_q   <= 40'h0;
      len_q   <= 17'h0;
      wp_q    <= 16'h0;
      fresh_q <= 17'h0;
    end else if (filt_clr_q) begin
      sum_q   <= 40'h0;
      len_q   <= 17'h0;
      fresh_q <= 17'h0;
    end else if (accept && avg_en_q) begin
      sum_q   <= sum_d;
      len_q   <= len_d;
      wp_q    <= wp_q + 16'h0001;
      fresh_q <= emit_now ? 17'h0 : fresh_q + 17'h00001;
    end
  end

  // ********
  // Shared divider
  // ********
  assign trial    = {div_rem_q[16:0], div_quo_q[47]};
  assign div_done = div_run_q && (div_cnt_q == `PWA_DIV_STEPS);

  always_ff @(posedge core_clk or negedge srst_n_q) begin
    if (!srst_n_q) begin
      div_run_q <= 1'b0;
      div_cnt_q <= 6'h0;
      div_quo_q <= 48'h0;
      div_rem_q <= 18'h0;
      div_den_q <= 17'h0;
    end else if (div_go) begin
      div_run_q <= 1'b1;
      div_cnt_q <= 6'h0;
      div_quo_q <= div_num;
      div_rem_q <= 18'h0;
      div_den_q <= div_den_d;
    end else if (div_done) begin
      div_run_q <= 1'b0;
    end else if (div_run_q) begin
      div_cnt_q <= div_cnt_q + 6'h01;
      if (trial >= {1'b0, div_den_q}) begin
        div_rem_q <= trial - {1'b0, div_den_q};
        div_quo_q <= {div_quo_q[46:0], 1'b1};
      end else begin
        div_rem_q <= trial;
        div_quo_q <= {div_quo_q[46:0], 1'b0};
      end
    end
  end

  // ********
  // Correction chain
  // ********
  assign gprod   = val_q * {16'h0, gain_q};
  assign gval    = (|gprod[47:46]) ? 32'hFFFFFFFF : gprod[45:`PWA_GAIN_SHIFT];
  assign dnum    = {17'h0, gval} * {32'h0, `PWA_PULSE_MAX};
  assign div_go  = (st_q == pwa_pkg::st_idle && accept && emit_now && avg_en_q)
                || (st_q == pwa_pkg::st_gain && pf_en_q);
  assign div_num = (st_q == pwa_pkg::st_gain) ? dnum[47:0] : {8'h0, sum_d};
  assign div_den_d = (st_q == pwa_pkg::st_gain) ? pf_q : len_d;

  // Level in 0.01 dB from a four-bit interpolated log2
  always_comb begin
    msb = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (val_q[i]) begin
        msb = 5'(i);
      end
    end
    norm  = val_q << (5'h1F - msb);
    dbx   = {9'h0, msb, norm[30:27]} * {9'h0, `PWA_DB_PER_OCT};
    lvl_d = {10'h0, dbx[17:4]} + (ofs_en_q ? {{8{ofs_q[15]}}, ofs_q} : 24'h0);
  end

  always_ff @(posedge core_clk or negedge srst_n_q) begin
    if (!srst_n_q) begin
      st_q <= pwa_pkg::st_idle;
    end else begin
      case (st_q)
        pwa_pkg::st_idle: begin
          if (accept && emit_now) begin
            st_q <= avg_en_q ? pwa_pkg::st_diva : pwa_pkg::st_gain;
          end
        end
        pwa_pkg::st_diva: begin
          if (div_done) begin
            st_q <= pwa_pkg::st_gain;
          end
        end
        pwa_pkg::st_gain: st_q <= pf_en_q ? pwa_pkg::st_divd : pwa_pkg::st_log;
        pwa_pkg::st_divd: begin
          if (div_done) begin
            st_q <= pwa_pkg::st_log;
          end
        end
        pwa_pkg::st_log:  st_q <= pwa_pkg::st_emit;
        pwa_pkg::st_emit: begin
          if (fif.wr_ready) begin
            st_q <= pwa_pkg::st_idle;
          end
        end
        default: st_q <= pwa_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge srst_n_q) begin
    if (!srst_n_q) begin
      val_q <= 32'h0;
      lvl_q <= 24'h0;
    end else begin
      case (st_q)
        pwa_pkg::st_idle: begin
          if (accept && !avg_en_q) begin
            val_q <= {8'h0, rdg_data};
          end
        end
        pwa_pkg::st_diva: begin
          if (div_done) begin
            val_q <= div_quo_q[31:0];
          end
        end
        pwa_pkg::st_gain: val_q <= gval;
        pwa_pkg::st_divd: begin
          if (div_done) begin
            val_q <= (|div_quo_q[47:32]) ? 32'hFFFFFFFF : div_quo_q[31:0];
          end
        end
        pwa_pkg::st_log: lvl_q <= lvl_d;
        default: ;
      endcase
    end
  end

  // ********
  // Result FIFO
  // ********
  // Full FIFO holds the engine in emit, which drops rdg_ready
  assign fif.wr_valid = (st_q == pwa_pkg::st_emit);
  assign fif.wr_data  = {val_q, lvl_q};
  assign fif.rd_ready = res_ready;
  assign res_valid    = fif.rd_valid;
  assign res_power    = fif.rd_data[55:24];
  assign res_level    = fif.rd_data[23:0];

  pwa_fifo #(.W(56), .D(8)) u_fifo (
    .clk   (core_clk),
    .rst_n (srst_n_q),
    .f     (fif.store)
  );

  // ********
  // Assertions
  // ********
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!srst_n_q);

  sequence s_avg_start;
    accept && emit_now && avg_en_q;
  endsequence

  sequence s_duty_start;
    st_q == pwa_pkg::st_gain && pf_en_q;
  endsequence

  count_range_a: assert property (
    count_q != 17'h0 && count_q <= `PWA_CNT_MAX) else $error("average count out of range");
  avg_dflt_a: assert property (
    $rose(srst_n_q) |-> avg_en_q && repeat_q && count_q == `PWA_R_COUNT) else $error("bad averaging defaults");
  corr_dflt_a: assert property (
    $rose(srst_n_q) |-> !pf_en_q && !ofs_en_q && pf_q == `PWA_R_PULSE && carrier_q == `PWA_R_CARRIER
                        && ofs_q == 16'h0 && chan_q == 2'h0) else $error("bad correction defaults");
  pass_thru_a: assert property (
    accept && !avg_en_q |=> st_q == pwa_pkg::st_gain && val_q == {8'h0, $past(rdg_data)}
                            && len_q == $past(len_q)) else $error("pass-through broken");
  clr_len_a: assert property (
    filt_clr_q |=> len_q == 17'h0 && fresh_q == 17'h0) else $error("filter reset failed");
  grow_len_a: assert property (
    accept && avg_en_q && !filt_clr_q && !full |=> len_q == $past(len_q) + 17'h00001) else $error("length not grown");
  repeat_hold_a: assert property (
    accept && avg_en_q && repeat_q && fresh_q + 17'h00001 < count_q |=> st_q == pwa_pkg::st_idle
      && fresh_q == $past(fresh_q) + 17'h00001) else $error("early result in repeat mode");
  settle_a: assert property (
    filt_clr_q && repeat_q && avg_en_q && count_q > 17'h00001 ##1 accept |=> st_q == pwa_pkg::st_idle)
    else $error("filter reset shortened settling");
  every_value_output_emit_a: assert property (
    accept && !repeat_q |=> st_q != pwa_pkg::st_idle) else $error("every_value_output result dropped");
  avg_done_a: assert property (
    s_avg_start |=> ##[48:50] st_q == pwa_pkg::st_gain) else $error("average not computed");
  duty_path_a: assert property (
    s_duty_start |=> st_q == pwa_pkg::st_divd && div_den_q == pf_q ##[48:50] st_q == pwa_pkg::st_log)
    else $error("pulse fraction division skipped");
  corr_order_a: assert property (
    st_q == pwa_pkg::st_gain && !pf_en_q |=> st_q == pwa_pkg::st_log ##1 st_q == pwa_pkg::st_emit)
    else $error("correction order broken");
  ofs_off_a: assert property (
    st_q == pwa_pkg::st_log && !ofs_en_q |=> !lvl_q[23]) else $error("offset applied while off");
  ofs_sign_a: assert property (
    st_q == pwa_pkg::st_log && ofs_en_q && !ofs_q[15] && ofs_q != 16'h0 |=> lvl_q != 24'h0)
    else $error("positive offset did not raise");
  chan_range_a: assert property (
    trace_chan_sel <= `PWA_CHAN_MAX) else $error("channel select out of range");
  pf_range_a: assert property (
    pf_q != 17'h0 && pf_q <= `PWA_PULSE_MAX) else $error("pulse fraction out of range");
  ofs_range_a: assert property (
    $signed(ofs_q) <= $signed(`PWA_OFS_MAX) && $signed(ofs_q) >= -$signed(`PWA_OFS_MAX))
    else $error("offset out of range");
endmodule // pwa_averager
`default_nettype wire

/* File: testbench/pwa_sink.sv */
// Result consumer model: prompt, every other cycle, or stalled
`timescale 1ns/100ps
`default_nettype none
module pwa_sink (
  input  wire logic        core_clk,
  input  wire logic [1:0]  mode,
  input  wire logic        res_valid,
  input  wire logic [31:0] res_power,
  input  wire logic [23:0] res_level,
  output logic             res_ready
);
  logic [55:0] q[$];
  logic        tgl_q = 1'b0;
  always_ff @(posedge core_clk) begin
    tgl_q <= !tgl_q;
    if (res_valid && res_ready) begin
      q.push_back({res_power, res_level});
    end
  end
  // Mode 2 stalls so the FIFO can be driven full
  assign res_ready = (mode == 2'h0) || (mode == 2'h1 && tgl_q);
endmodule // pwa_sink
`default_nettype wire

/* File: testbench/pwa_averager_tb_top.sv */
// Self-checking bench of the power averager
`timescale 1ns/100ps
`default_nettype none
`include "pwa_map.svh"
module pwa_averager_tb_top;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        rdg_valid = 1'b0;
  logic [23:0] rdg_data = 24'h0;
  logic        rdg_ready;
  logic        res_valid;
  logic        res_ready;
  logic [31:0] res_power;
  logic [23:0] res_level;
  logic [1:0]  trace_chan_sel;
  logic [1:0]  sink_mode = 2'h0;
  int          err_count = 0;
  int          tests_run = 0;
  always #5 core_clk = !core_clk;
  pwa_averager i_pwa_averager (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rdg_valid(rdg_valid), .rdg_data(rdg_data), .rdg_ready(rdg_ready), .res_valid(res_valid),
    .res_ready(res_ready), .res_power(res_power), .res_level(res_level),
    .trace_chan_sel(trace_chan_sel));
  pwa_sink i_pwa_sink (.core_clk(core_clk), .mode(sink_mode), .res_valid(res_valid),
    .res_power(res_power), .res_level(res_level), .res_ready(res_ready));
  // ********
  // Bus and stream tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic send(input logic [23:0] d);
    @(posedge core_clk);
    rdg_data  <= d;
    rdg_valid <= 1'b1;
    do @(negedge core_clk); while (rdg_ready !== 1'b1);
    @(posedge core_clk);
    rdg_valid <= 1'b0;
  endtask
  task automatic get(output logic [31:0] p, output logic [23:0] l);
    int n;
    n = 0;
    while (i_pwa_sink.q.size() == 0 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(n < 400), 32'h1);
    {p, l} = (n < 400) ? i_pwa_sink.q.pop_front() : 56'h0;
  endtask
  task automatic none();
    repeat (150) @(posedge core_clk);
    chk(32'(i_pwa_sink.q.size()), 32'h0);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_defaults();
    rdc(`PWA_A_CTRL, 32'h3);
    rdc(`PWA_A_COUNT, 32'h4);
    rdc(`PWA_A_CARRIER, 32'h00989680);
    rdc(`PWA_A_GAIN, 32'h4000);
    rdc(`PWA_A_PULSE, 32'h3E8);
    rdc(`PWA_A_OFFSET, 32'h0);
    rdc(`PWA_A_CHAN, 32'h0);
    rdc(8'h20, 32'h0);
    wr(`PWA_A_CHAN, 32'h2);
    wr(`PWA_A_CHAN, 32'h3);
    @(negedge core_clk);
    chk(32'(trace_chan_sel), 32'h2);
    wr(`PWA_A_COUNT, 32'h0);
    wr(`PWA_A_COUNT, 32'h10001);
    rdc(`PWA_A_COUNT, 32'h4);
    wr(`PWA_A_COUNT, 32'h10000);
    rdc(`PWA_A_COUNT, 32'h10000);
    wr(`PWA_A_PULSE, 32'h186A1);
    rdc(`PWA_A_PULSE, 32'h3E8);
    wr(`PWA_A_COUNT, 32'h4);
  endtask
  task automatic t_repeat();
    logic [31:0] p;
    logic [23:0] l;
    repeat (3) send(24'h64);
    rdc(`PWA_A_STATUS, 32'h3);
    none();
    send(24'h64);
    get(p, l);
    chk(p, 32'h64);
    rdc(`PWA_A_STATUS, 32'h20004);
    send(24'h64);
    send(24'h64);
    wr(`PWA_A_CTRL, 32'h13);
    repeat (3) send(24'h12C);
    none();
    send(24'h12C);
    get(p, l);
    chk(p, 32'h12C);
  endtask
  task automatic t_every_value_output();
    logic [31:0] p;
    logic [23:0] l;
    wr(`PWA_A_CTRL, 32'h1);
    wr(`PWA_A_COUNT, 32'h2);
    sink_mode <= 2'h1;
    send(24'h64);
    get(p, l);
    chk(p, 32'h64);
    send(24'h12C);
    get(p, l);
    chk(p, 32'hC8);
    send(24'h1F4);
    get(p, l);
    chk(p, 32'h190);
    wr(`PWA_A_GAIN, 32'h8000);
    send(24'h1F4);
    get(p, l);
    chk(p, 32'h3E8);
    wr(`PWA_A_GAIN, 32'h4000);
    sink_mode <= 2'h0;
  endtask
  task automatic t_bypass();
    logic [31:0] p;
    logic [23:0] l;
    wr(`PWA_A_CTRL, 32'h0);
    send(24'h1F4);
    get(p, l);
    chk(p, 32'h1F4);
    wr(`PWA_A_PULSE, 32'hC350);
    wr(`PWA_A_CTRL, 32'h4);
    send(24'h64);
    get(p, l);
    chk(p, 32'hC8);
  endtask
  task automatic t_offset();
    logic [31:0] p;
    logic [23:0] l0;
    logic [23:0] l1;
    wr(`PWA_A_CTRL, 32'h0);
    wr(`PWA_A_OFFSET, 32'hC8);
    send(24'h400);
    get(p, l0);
    chk({8'h0, l0}, 32'hBC2);
    wr(`PWA_A_CTRL, 32'h8);
    send(24'h400);
    get(p, l1);
    chk({8'h0, l1 - l0}, 32'hC8);
    wr(`PWA_A_OFFSET, 32'hFF38);
    send(24'h400);
    get(p, l1);
    chk({8'h0, l1 - l0}, 32'hFFFF38);
    wr(`PWA_A_CTRL, 32'h0);
    send(24'h400);
    get(p, l1);
    chk({8'h0, l1}, 32'hBC2);
  endtask
  task automatic t_fifo();
    logic [31:0] p;
    logic [23:0] l;
    sink_mode <= 2'h2;
    // Eight fill the FIFO, the ninth parks the engine in emit
    for (int i = 1; i <= 9; i++) send(24'(i));
    repeat (120) @(posedge core_clk);
    @(negedge core_clk);
    chk(32'(rdg_ready), 32'h0);
    chk(32'(res_valid), 32'h1);
    sink_mode <= 2'h0;
    for (int i = 1; i <= 9; i++) begin
      get(p, l);
      chk(p, 32'(i));
    end
  endtask
  task automatic results();
    $display("mismatches=%0d comparisons=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_defaults();
    t_repeat();
    t_every_value_output();
    t_bypass();
    t_offset();
    t_fifo();
    results();
  end
  // About 30 readings at up to 110 cycles each, with ample margin
  initial begin
    #300000;
    chk(32'h0, 32'h1);
    results();
  end
endmodule // pwa_averager_tb_top
`default_nettype wire
